// ===== cassette_consts.svh
// Named constants for the cassette tape interface
`ifndef CASSETTE_CONSTS_SVH
`define CASSETTE_CONSTS_SVH

`define ADDR_W        8
`define DATA_W        32
`define OFF_CTRL      8'h00
`define OFF_STATUS    8'h04
`define OFF_MASK      8'h08
`define OFF_CHAR      8'h0C
`define OFF_COUNT     8'h10
`define OFF_STATE     8'h14
`define CMD_START     0
`define CMD_STOP      1
`define CMD_REWIND    2
`define CMD_REW_END   3
`define ST_W          3
`define ST_RESET      3'h0
`define LOWER_W       16
`define LOWER_RESET   16'h0000
`define CHAR_W        10
`define MARK_POS      9
`define COUNT_W       16
`define COUNT_RESET   16'h0000
`define COUNT_STEP    16'h0001
`define MCLK_NS       5
`define REWIND_PULSE_NS 1000
`define REWIND_CYC    ((`REWIND_PULSE_NS + `MCLK_NS - 1) / `MCLK_NS)
`define REW_CNT_W     8
`define REW_CNT_ZERO  8'h00
`define GAP_US        50
`define GAP_CYC       (`GAP_US * 1000 / `MCLK_NS)
`define GAP_CNT_W     14
`define GAP_CNT_ZERO  14'h0000
`define GAP_CNT_STEP  14'h0001

`endif

// ===== cassette_pkg.sv
// Types shared by the cassette tape interface
`default_nettype none
package cassette_pkg;

   // Pins arriving from the cassette unit
   typedef struct packed {
      logic tape_clock_pulse;
      logic read_info;
      logic cassette_ready;
   } pins_t;

   // Sticky event bits, same layout in status and mask
   typedef struct packed {
      logic gap_stop;
      logic parity_error;
      logic char_done;
   } events_t;

   // Bit-assembly phases
   typedef enum logic [5:0] {
      PH_IDLE = 6'h01,
      PH_T0   = 6'h02,
      PH_T1   = 6'h04,
      PH_T2   = 6'h08,
      PH_T3   = 6'h10,
      PH_HOLD = 6'h20
   } phase_t;

endpackage
`default_nettype wire

// ===== sync_stage.sv
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module sync_stage #(
   parameter int WIDTH = 1
) (
   input  wire logic             mclk_i,  // System clock
   input  wire logic             rst_i,   // Async reset, active high
   input  wire logic             ce_i,    // Clock enable
   input  wire logic [WIDTH-1:0] d_i,     // Asynchronous input
   output var  logic [WIDTH-1:0] q_o      // Synchronised output
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         meta <= '0;
         q_o  <= '0;
      end else if (ce_i) begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule
`default_nettype wire

// ===== cassette_tape_interface.sv
// Cassette tape control and serial character assembly
//
// What this block does
// - Stop command halts tape at next gap
// - Accumulate bits only while accumulate enabled
// - Clear or start resets state, enables accumulate
// - Hold rewind output throughout rewind
// - Send rewind pulse to start rewind
// - Forward drive only while cassette ready
// - Bit during tape clock raises event
// - First phase lasts exactly one clock
// - Clear assembly register, parity before character
// - Leading one at sense position completes character
// - Count each character in fourth phase
`timescale 1ns/1ps
`default_nettype none
`include "cassette_consts.svh"
module cassette_tape_interface #(
   parameter int GAP_CYCLES = `GAP_CYC
) (
   input  wire logic                  mclk_i,               // 200 MHz system clock
   input  wire logic                  rst_i,                // Async reset, active high
   input  wire logic                  ce_i,                 // Clock enable, freezes state
   input  wire logic                  gen_clear_i,          // General processor clear
   input  wire logic [`ADDR_W-1:0]    addr_i,               // Register address
   input  wire logic [`DATA_W-1:0]    wdata_i,              // Write data
   input  wire logic                  wr_i,                 // Write strobe
   input  wire logic                  rd_i,                 // Read strobe
   output var  logic [`DATA_W-1:0]    rdata_o,              // Read data, cycle after rd_i
   input  wire cassette_pkg::pins_t   pins_i,               // Pins from cassette unit
   output var  logic                  forward_drive_start_o, // Forward drive command
   output var  logic                  stop_at_gap_o,        // Stop at next gap
   output var  logic                  rewind_hold_o,        // Held during rewind
   output var  logic                  rewind_pulse_out_o,   // Rewind pulse to cassette
   output var  logic                  irq_o                 // Level interrupt
);
   localparam logic [`GAP_CNT_W-1:0] GAP_LAST = `GAP_CNT_W'(GAP_CYCLES - 1);
   localparam logic [`REW_CNT_W-1:0] REW_LEN  = `REW_CNT_W'(`REWIND_CYC);

   cassette_pkg::pins_t   pins_s;
   cassette_pkg::phase_t  phase;
   cassette_pkg::phase_t  next_phase;
   cassette_pkg::events_t status;
   cassette_pkg::events_t mask;
   cassette_pkg::events_t events;
   cassette_pkg::events_t next_status;

   logic                  accumulate_enable;
   logic                  motion;
   logic                  parity_error_flag;
   logic                  clk_d;
   logic                  event_d;
   logic                  cell_seen;
   logic                  shift_bit;
   logic [`LOWER_W-1:0]   lower;
   logic [`CHAR_W-1:0]    char_hold;
   logic [`COUNT_W-1:0]   byte_count;
   logic [`GAP_CNT_W-1:0] gap_cnt;
   logic [`REW_CNT_W-1:0] rew_cnt;

   // All cassette pins, the short clock and read pulses included, are sampled twice before use
   sync_stage #(
      .WIDTH ($bits(cassette_pkg::pins_t))
   ) u_pin_sync (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .d_i    (pins_i),
      .q_o    (pins_s)
   );

   // Register decode
   wire wr_en      = wr_i & ce_i;
   wire rd_en      = rd_i & ce_i;
   wire wr_ctrl    = wr_en & (addr_i == `OFF_CTRL);
   wire wr_mask    = wr_en & (addr_i == `OFF_MASK);
   wire rd_status  = rd_en & (addr_i == `OFF_STATUS);
   wire start_cmd  = wr_ctrl & wdata_i[`CMD_START];
   wire stop_cmd   = wr_ctrl & wdata_i[`CMD_STOP];
   wire rewind_cmd = wr_ctrl & wdata_i[`CMD_REWIND];
   wire rew_end    = wr_ctrl & wdata_i[`CMD_REW_END];

   // Processor clear or any start command
   wire tape_start_reset = gen_clear_i | start_cmd;

   // Bit cell: a one arrives as read level during clock high; a cell with none is a zero
   wire tape_clock_in_event = accumulate_enable & pins_s.tape_clock_pulse
                              & pins_s.read_info;
   wire start_one  = tape_clock_in_event & ~event_d;
   wire clk_fell   = clk_d & ~pins_s.tape_clock_pulse;
   wire start_zero = accumulate_enable & clk_fell & ~cell_seen;
   wire phase_go   = (phase == cassette_pkg::PH_IDLE) & (start_one | start_zero);

   wire character_marker_sense = lower[`MARK_POS];
   wire character_count_strobe = (phase == cassette_pkg::PH_T3)
                                 & character_marker_sense;
   wire character_clear  = tape_start_reset | character_count_strobe;
   wire parity_bad       = ~(^lower[`CHAR_W-2:0]);

   // Gap: tape clock low well beyond its normal low time
   wire gap_hit = stop_at_gap_o & motion & (gap_cnt == GAP_LAST);

   // Bit-assembly phase sequencer
   always_comb begin
      next_phase = phase;
      case (phase)
         cassette_pkg::PH_IDLE: begin
            if (phase_go) begin
               next_phase = cassette_pkg::PH_T0;
            end
         end
         cassette_pkg::PH_T0:   next_phase = cassette_pkg::PH_T1;
         cassette_pkg::PH_T1:   next_phase = cassette_pkg::PH_T2;
         cassette_pkg::PH_T2:   next_phase = cassette_pkg::PH_T3;
         cassette_pkg::PH_T3:   next_phase = cassette_pkg::PH_HOLD;
         cassette_pkg::PH_HOLD: begin
            if (!tape_clock_in_event) begin
               next_phase = cassette_pkg::PH_IDLE;
            end
         end
         default: next_phase = cassette_pkg::PH_IDLE;
      endcase
      if (tape_start_reset) begin
         next_phase = cassette_pkg::PH_IDLE;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         phase   <= cassette_pkg::PH_IDLE;
         clk_d   <= 1'b0;
         event_d <= 1'b0;
      end else if (ce_i) begin
         phase   <= next_phase;
         clk_d   <= pins_s.tape_clock_pulse;
         event_d <= tape_clock_in_event;
      end
   end

   // Cell bookkeeping and shift bit capture
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cell_seen <= 1'b0;
         shift_bit <= 1'b0;
      end else if (ce_i) begin
         if (tape_start_reset || clk_fell) begin
            cell_seen <= 1'b0;
         end else if (tape_clock_in_event) begin
            cell_seen <= 1'b1;
         end
         if (phase_go) begin
            shift_bit <= start_one;
         end
      end
   end

   // Lower assembly register, parity flag, character and byte count
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         lower             <= `LOWER_RESET;
         parity_error_flag <= 1'b0;
         char_hold         <= '0;
         byte_count        <= `COUNT_RESET;
      end else if (ce_i) begin
         if (character_clear) begin
            lower <= `LOWER_RESET;
         end else if (phase == cassette_pkg::PH_T2) begin
            lower <= {lower[`LOWER_W-2:0], shift_bit};
         end
         if (tape_start_reset) begin
            parity_error_flag <= 1'b0;
         end else if (character_count_strobe) begin
            parity_error_flag <= parity_bad;
         end
         if (character_count_strobe) begin
            char_hold  <= lower[`CHAR_W-1:0];
            byte_count <= byte_count + `COUNT_STEP;
         end
      end
   end

   // Tape motion, stop at gap, accumulate enable
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         motion            <= 1'b0;
         stop_at_gap_o     <= 1'b0;
         accumulate_enable <= 1'b0;
         gap_cnt           <= `GAP_CNT_ZERO;
      end else if (ce_i) begin
         if (gen_clear_i || rewind_cmd || gap_hit) begin
            motion <= 1'b0;
         end else if (start_cmd) begin
            motion <= 1'b1;
         end
         if (tape_start_reset || gap_hit) begin
            stop_at_gap_o <= 1'b0;
         end else if (stop_cmd) begin
            stop_at_gap_o <= 1'b1;
         end
         if (tape_start_reset) begin
            accumulate_enable <= 1'b1;
         end else if (gap_hit) begin
            accumulate_enable <= 1'b0;
         end
         // Counts only once a stop is armed, so a long low before it cannot overrun the match
         if (pins_s.tape_clock_pulse || !motion || !stop_at_gap_o || gap_hit) begin
            gap_cnt <= `GAP_CNT_ZERO;
         end else begin
            gap_cnt <= gap_cnt + `GAP_CNT_STEP;
         end
      end
   end

   // Forward drive and rewind outputs
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         forward_drive_start_o <= 1'b0;
         rewind_hold_o         <= 1'b0;
         rewind_pulse_out_o    <= 1'b0;
         rew_cnt               <= `REW_CNT_ZERO;
      end else if (ce_i) begin
         forward_drive_start_o <= motion & ~gap_hit & pins_s.cassette_ready
                                  & ~rewind_hold_o;
         if (gen_clear_i || rew_end) begin
            rewind_hold_o <= 1'b0;
         end else if (rewind_cmd) begin
            rewind_hold_o <= 1'b1;
         end
         if (gen_clear_i) begin
            rew_cnt <= `REW_CNT_ZERO;
         end else if (rewind_cmd) begin
            rew_cnt <= REW_LEN;
         end else if (rew_cnt != `REW_CNT_ZERO) begin
            rew_cnt <= rew_cnt - `REW_CNT_W'(1);
         end
         rewind_pulse_out_o <= ~gen_clear_i & (rewind_cmd | (rew_cnt > `REW_CNT_W'(1)));
      end
   end

   // Sticky status, cleared by a read; a new event wins over the clear
   assign events.gap_stop     = gap_hit;
   assign events.parity_error = character_count_strobe & parity_bad;
   assign events.char_done    = character_count_strobe;
   assign next_status = (rd_status ? `ST_RESET : status) | events;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         status <= `ST_RESET;
         mask   <= `ST_RESET;
         irq_o  <= 1'b0;
      end else if (ce_i) begin
         status <= next_status;
         if (wr_mask) begin
            mask <= wdata_i[`ST_W-1:0];
         end
         irq_o <= |(next_status & mask);
      end
   end

   // Read selection
   wire [`DATA_W-1:0] state_word = `DATA_W'({pins_s.cassette_ready, accumulate_enable,
                                    motion, stop_at_gap_o, rewind_hold_o,
                                    parity_error_flag, phase});
   wire [`DATA_W-1:0] rd_word =
      (addr_i == `OFF_CTRL)   ? `DATA_W'({rewind_hold_o, stop_at_gap_o, motion}) :
      (addr_i == `OFF_STATUS) ? `DATA_W'(status) :
      (addr_i == `OFF_MASK)   ? `DATA_W'(mask) :
      (addr_i == `OFF_CHAR)   ? `DATA_W'(char_hold) :
      (addr_i == `OFF_COUNT)  ? `DATA_W'(byte_count) :
      (addr_i == `OFF_STATE)  ? state_word : '0;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= '0;
      end else if (ce_i) begin
         rdata_o <= rd_en ? rd_word : '0;
      end
   end

   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i || !ce_i);

   t0_one_cycle_a: assert property (phase == cassette_pkg::PH_T0 |=> phase == cassette_pkg::PH_T1)
      else $error("first assembly phase not exactly one cycle");
   event_starts_a: assert property (phase == cassette_pkg::PH_IDLE && start_one && !tape_start_reset
      |=> phase == cassette_pkg::PH_T0)
      else $error("tape clock in event did not start phase sequence");
   gated_idle_a: assert property (phase == cassette_pkg::PH_IDLE && !accumulate_enable
      && !tape_start_reset |=> phase == cassette_pkg::PH_IDLE)
      else $error("bit accepted while accumulate disabled");
   drive_ready_a: assert property (forward_drive_start_o |-> $past(pins_s.cassette_ready))
      else $error("forward drive without cassette ready");
   stop_cmd_a: assert property (stop_cmd && !tape_start_reset && !gap_hit |=> stop_at_gap_o)
      else $error("stop at gap not raised after command");
   rewind_start_a: assert property (rewind_cmd && !gen_clear_i
      |=> rewind_pulse_out_o && rewind_hold_o ##1 rewind_pulse_out_o[*8])
      else $error("rewind pulse or hold missing");
   rewind_held_a: assert property (rewind_hold_o && !gen_clear_i && !rew_end |=> rewind_hold_o)
      else $error("rewind hold dropped during rewind");
   start_reset_a: assert property (tape_start_reset |=> accumulate_enable && lower == `LOWER_RESET
      && !parity_error_flag && phase == cassette_pkg::PH_IDLE)
      else $error("start reset did not clear cassette state");
   count_step_a: assert property (character_count_strobe && !tape_start_reset
      |=> byte_count == $past(byte_count) + `COUNT_STEP && lower == `LOWER_RESET)
      else $error("character not counted or register not cleared");
   one_shift_a: assert property (phase == cassette_pkg::PH_T2 |=> phase != cassette_pkg::PH_T2
      [*1] ##1 (phase != cassette_pkg::PH_T2))
      else $error("extra shift within one event");
   marker_a: assert property (phase == cassette_pkg::PH_T3 && lower[`MARK_POS]
      |=> status.char_done)
      else $error("completed character not flagged");

   char_seen_c:  cover property (character_count_strobe);
   gap_stop_c:   cover property (gap_hit);
   rewind_end_c: cover property (rewind_hold_o ##1 !rewind_hold_o);
   irq_c:        cover property ($rose(irq_o));
endmodule
`default_nettype wire

// ===== cassette_unit.sv
// Behavioural cassette drive: ready level, framed tape clock and serial read bits
`timescale 1ns/1ps
`default_nettype none
module cassette_unit (
   input  wire logic                ready_i, // Unit ready level from the bench
   output var  cassette_pkg::pins_t pins_o   // Pins toward the interface
);
   logic clock_level = 1'b0;
   logic info_level  = 1'b0;

   assign pins_o = {clock_level, info_level, ready_i};

   // One record cell per bit, 64 ns; clock stands low outside the frame
   // Read level sits late in the clock-high part, so a zero cell has finished assembly
   task automatic send_char(input logic [9:0] c);
      #0.7;
      for (int i = 9; i >= 0; i--) begin
         clock_level = 1'b1;
         #25 info_level = c[i];
         #20 info_level = 1'b0;
         #5 clock_level = 1'b0;
         #14;
      end
   endtask
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the cassette tape interface
`timescale 1ns/1ps
`default_nettype none
`include "cassette_consts.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin errors++; \
   $display("Error t=%0t got %h exp %h", $time, got, exp); end end
module tb;
   localparam int GAP = 40;
   logic                mclk_i      = 1'b0;
   logic                rst_i       = 1'b1;
   logic                ce_i        = 1'b1;
   logic                gen_clear_i = 1'b0;
   logic [`ADDR_W-1:0]  addr_i      = '0;
   logic [`DATA_W-1:0]  wdata_i     = '0;
   logic                wr_i        = 1'b0;
   logic                rd_i        = 1'b0;
   logic                ready       = 1'b0;
   logic [`DATA_W-1:0]  rdata_o;
   cassette_pkg::pins_t pins;
   logic                fwd_o;
   logic                stop_o;
   logic                hold_o;
   logic                pulse_o;
   logic                irq_o;
   int                  errors      = 0;
   int                  tests_run   = 0;
   int                  n;
   int                  m;
   logic [31:0]         seed        = 32'h00010322;
   logic [31:0]         rv;
   logic [15:0]         exp_cnt     = '0;
   logic [8:0]          d;

   always #2.5 mclk_i = ~mclk_i;

   cassette_tape_interface #(.GAP_CYCLES(GAP)) dut (
      .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .gen_clear_i(gen_clear_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .pins_i(pins), .forward_drive_start_o(fwd_o), .stop_at_gap_o(stop_o),
      .rewind_hold_o(hold_o), .rewind_pulse_out_o(pulse_o), .irq_o(irq_o)
   );

   cassette_unit unit (.ready_i(ready), .pins_o(pins));

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // Odd parity over the nine bits after the marker
   function automatic logic [31:0] exp_status(input logic [8:0] b);
      return {29'h0, 1'b0, ~^b, 1'b1};
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge mclk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
      rd(a, rv);
      `CHK(rv, e)
   endtask

   task automatic settle(input int c);
      repeat (c) @(posedge mclk_i);
      #1;
   endtask

   task automatic send(input logic [8:0] b, input logic take);
      unit.send_char({1'b1, b});
      settle(8);
      if (take) exp_cnt = exp_cnt + 16'h0001;
      chk_rd(`OFF_COUNT, {16'h0, exp_cnt});
   endtask

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      #100us;
      errors++;
      end_of_test();
   end

   initial begin
      repeat (16) @(posedge mclk_i);
      rst_i <= 1'b0;
      chk_rd(`OFF_CTRL, 32'h0);
      chk_rd(`OFF_STATUS, 32'h0);
      chk_rd(`OFF_MASK, 32'h0);
      chk_rd(8'h20, 32'h0);
      send(9'h0AA, 1'b0);
      ready <= 1'b1;
      wr(`OFF_CTRL, 32'h1);
      settle(4);
      `CHK(fwd_o, 1'b1)
      rd(`OFF_STATE, rv);
      `CHK(rv[10], 1'b1)
      ready <= 1'b0;
      settle(4);
      `CHK(fwd_o, 1'b0)
      ready <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         seed = xorshift(seed);
         d = seed[8:0];
         if (i == 0) d = 9'h000;
         if (i == 1) d = 9'h1FF;
         send(d, 1'b1);
         chk_rd(`OFF_CHAR, {22'h0, 1'b1, d});
         `CHK(irq_o, 1'b0)
         wr(`OFF_MASK, 32'h1);
         settle(2);
         `CHK(irq_o, 1'b1)
         chk_rd(`OFF_STATUS, exp_status(d));
         settle(2);
         `CHK(irq_o, 1'b0)
         wr(`OFF_MASK, 32'h0);
      end
      wr(`OFF_CTRL, 32'h2);
      chk_rd(`OFF_CTRL, 32'h3);
      `CHK(stop_o, 1'b1)
      settle(GAP + 10);
      `CHK({stop_o, fwd_o}, 2'b00)
      chk_rd(`OFF_STATUS, 32'h4);
      send(9'h155, 1'b0);
      @(posedge mclk_i);
      gen_clear_i <= 1'b1;
      @(posedge mclk_i);
      gen_clear_i <= 1'b0;
      rd(`OFF_STATE, rv);
      `CHK(rv[10:0], 11'h401)
      send(9'h0F0, 1'b1);
      wr(`OFF_CTRL, 32'h4);
      #1;
      m = 0;
      for (n = 0; n < 400 && pulse_o === 1'b1; n++) begin
         if (hold_o !== 1'b1) m++;
         settle(1);
      end
      `CHK(n, `REWIND_CYC)
      `CHK(m, 0)
      settle(10);
      `CHK({hold_o, fwd_o}, 2'b10)
      wr(`OFF_CTRL, 32'h8);
      settle(2);
      `CHK(hold_o, 1'b0)
      @(posedge mclk_i);
      ce_i <= 1'b0;
      wr(`OFF_MASK, 32'h7);
      @(posedge mclk_i);
      ce_i <= 1'b1;
      chk_rd(`OFF_MASK, 32'h0);
      end_of_test();
   end
endmodule
`default_nettype wire
